// File: core/mxd_pkg.sv
// shared constants of the xram/sfr transfer engine
package mxd_pkg;
  // channel count and field widths
  localparam int NUM_CH    = 7;
  localparam int BASE_W    = 12;
  localparam int OFF_W     = 10;
  localparam int DATA_W    = 8;
  localparam int CFG_W     = 12;
  localparam int FUNC_W    = 3;
  localparam int NUM_FUNC  = 8;

  // configuration indices on cfg_idx
  localparam logic [2:0] CFG_CTRL = 3'h0;
  localparam logic [2:0] CFG_BASE = 3'h1;
  localparam logic [2:0] CFG_OFF  = 3'h2;
  localparam logic [2:0] CFG_SIZE = 3'h3;
  localparam logic [2:0] CFG_MODE = 3'h4;
  localparam logic [2:0] CFG_SEL  = 3'h5;

  // channel_control bit positions
  localparam int CTL_FUNC_LSB = 0;
  localparam int CTL_WORD     = 3;
  localparam int CTL_ENDIAN   = 4;
  localparam int CTL_STALL    = 5;
  localparam int CTL_MID_IE   = 6;
  localparam int CTL_FULL_IE  = 7;

  // channel_wrap_mode bit position
  localparam int MODE_WRAP = 0;

  // function_select codes
  localparam logic [2:0] FN_X2ENC  = 3'h0;
  localparam logic [2:0] FN_ENC2X  = 3'h1;
  localparam logic [2:0] FN_X2CRC  = 3'h2;
  localparam logic [2:0] FN_X2SPI  = 3'h3;
  localparam logic [2:0] FN_SPI2X  = 3'h4;
  localparam logic [2:0] FN_X2KEY  = 3'h5;
  localparam logic [2:0] FN_X2BLK  = 3'h6;
  localparam logic [2:0] FN_RES2X  = 3'h7;

  // control reset value and bytes per transaction
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] BYTES_WORD = 2'h2;
  localparam logic [1:0] BYTES_BYTE = 2'h1;

  // engine state, gray along idle -> run
  typedef enum logic [0:0] {
    MXD_IDLE = 1'h0,
    MXD_RUN  = 1'h1
  } mxd_state_e_t;
endpackage : mxd_pkg

// File: core/mxd_engine.sv
// seven-channel xram/sfr transfer engine with shared-bus access
`timescale 1ns/1ps
// Notes on behaviour
// - seven independent channels, each fully configured
// - selector picks which channel software configures
// - low control bits select transfer function
// - control holds byte order, stall, interrupt enables
// - stall finishes current transaction, blocks new
// - base 12 bits, offset 10, size 10
// - xram address is base plus offset
// - offset counts up one per byte
// - full-length flag when offset reaches size
// - midpoint flag at half size, odd rounds up
// - flags stay until cleared, block channel
// - xram-to-sfr two cycles pipelined, reverse one
// - transactions start only while channel enable set
// - active channel shows busy, ignores address writes
// - software setting active bit forces a transfer
// - without wrap stop at end, with wrap restart
// - cpu wins the shared bus
// - fixed priority, channel 0 first, at boundaries
// - engine holds in debug, reports sleep readiness
// - enable register bit 7 reads zero
module mxd_engine #(
  parameter int NCH = mxd_pkg::NUM_CH
) (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rstn,
  // per-channel configuration through the selector
  input  wire logic                        cfg_we,
  input  wire logic [2:0]                  cfg_idx,
  input  wire logic [mxd_pkg::CFG_W-1:0]   cfg_wdata,
  output logic      [mxd_pkg::CFG_W-1:0]   cfg_rdata,
  // common registers
  input  wire logic                        en_we,
  input  wire logic [7:0]                  en_wdata,
  output logic      [7:0]                  channel_enable_register,
  input  wire logic [NCH-1:0]              act_set,
  output logic      [7:0]                  channel_active_register,
  input  wire logic [NCH-1:0]              clr_full,
  input  wire logic [NCH-1:0]              clr_mid,
  output logic      [7:0]                  full_length_flag_register,
  output logic      [7:0]                  midpoint_flag_register,
  output logic                             irq,
  // peripheral requests per function
  input  wire logic [mxd_pkg::NUM_FUNC-1:0] func_req,
  output logic      [mxd_pkg::NUM_FUNC-1:0] func_ack,
  // system state
  input  wire logic                        cpu_busy,
  input  wire logic                        debug_mode,
  output logic                             sleep_ok,
  // xram side
  output logic      [mxd_pkg::BASE_W-1:0]  xram_addr,
  output logic                             xram_rd,
  output logic                             xram_wr,
  output logic      [mxd_pkg::DATA_W-1:0]  xram_wdata,
  input  wire logic [mxd_pkg::DATA_W-1:0]  xram_rdata,
  // sfr side
  output logic      [mxd_pkg::FUNC_W-1:0]  sfr_func,
  output logic                             sfr_rd,
  output logic                             sfr_wr,
  output logic      [mxd_pkg::DATA_W-1:0]  sfr_wdata,
  input  wire logic [mxd_pkg::DATA_W-1:0]  sfr_rdata,
  output logic                             sfr_msb_first
);
  typedef struct packed {
    mxd_pkg::mxd_state_e_t                  st;
    logic [2:0]                             sel;
    logic [2:0]                             gr;
    logic [1:0]                             left;
    logic                                   pipe_v;
    logic [mxd_pkg::DATA_W-1:0]             pipe_d;
    logic [NCH-1:0]                         en;
    logic [NCH-1:0]                         wrap;
    logic [NCH-1:0]                         full;
    logic [NCH-1:0]                         mid;
    logic [NCH-1:0]                         force_req;
    logic [NCH-1:0][7:0]                    ctrl;
    logic [NCH-1:0][mxd_pkg::BASE_W-1:0]    base;
    logic [NCH-1:0][mxd_pkg::OFF_W-1:0]     off;
    logic [NCH-1:0][mxd_pkg::OFF_W-1:0]     size;
    logic [mxd_pkg::CFG_W-1:0]              rdata;
  } mxd_state_t;

  mxd_state_t s;
  mxd_state_t next_s;

  logic [NCH-1:0]  elig;
  logic [NCH-1:0]  active;
  logic [2:0]      pick;
  logic            hold;
  logic            start;
  logic            step;
  logic            to_x;
  logic [mxd_pkg::OFF_W-1:0] inc_off;
  logic [mxd_pkg::OFF_W-1:0] mid_off;

  // functions that move data from an sfr into xram
  function automatic logic is_to_xram(input logic [2:0] f);
    is_to_xram = (f == mxd_pkg::FN_ENC2X) || (f == mxd_pkg::FN_SPI2X) || (f == mxd_pkg::FN_RES2X);
  endfunction : is_to_xram

  function automatic logic [mxd_pkg::OFF_W-1:0] midpoint(input logic [mxd_pkg::OFF_W-1:0] sz);
    midpoint = (sz >> 1) + {{(mxd_pkg::OFF_W-1){1'b0}}, sz[0]};
  endfunction : midpoint

  // eligibility per channel; cpu and debug hold everything
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      // enable gates, stall blocks, flags block, force
      elig[i] = s.en[i] & ~s.ctrl[i][mxd_pkg::CTL_STALL] & ~s.full[i] & ~s.mid[i]
                & (s.off[i] < s.size[i])
                & (func_req[s.ctrl[i][2:0]] | s.force_req[i]);
      active[i] = ((s.st == mxd_pkg::MXD_RUN) && (s.gr == 3'(i))) | s.force_req[i];
    end
  end

  always_comb begin
    pick = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (elig[i]) begin
        pick = 3'(i);
      end
    end
  end

  assign hold    = cpu_busy | debug_mode;
  assign start   = (s.st == mxd_pkg::MXD_IDLE) && !hold && (|elig);
  assign step    = (s.st == mxd_pkg::MXD_RUN) && !hold && (s.left != 2'h0);
  assign to_x    = is_to_xram(s.ctrl[s.gr][2:0]);
  assign inc_off = s.off[s.gr] + 10'h001;
  assign mid_off = midpoint(s.size[s.gr]);

  // next state and bus strobes
  always_comb begin
    next_s   = s;
    xram_rd  = 1'b0;
    xram_wr  = 1'b0;
    sfr_rd   = 1'b0;
    sfr_wr   = 1'b0;
    func_ack = '0;
    next_s.full = s.full & ~clr_full;
    next_s.mid  = s.mid & ~clr_mid;
    // configuration goes to the selected channel
    if (cfg_we) begin
      unique case (cfg_idx)
        mxd_pkg::CFG_SEL:  next_s.sel = cfg_wdata[2:0];
        mxd_pkg::CFG_CTRL: next_s.ctrl[s.sel] = cfg_wdata[7:0];
        mxd_pkg::CFG_MODE: next_s.wrap[s.sel] = cfg_wdata[mxd_pkg::MODE_WRAP];
        mxd_pkg::CFG_BASE: if (!active[s.sel]) next_s.base[s.sel] = cfg_wdata;
        mxd_pkg::CFG_OFF:  if (!active[s.sel]) next_s.off[s.sel] = cfg_wdata[mxd_pkg::OFF_W-1:0];
        mxd_pkg::CFG_SIZE: if (!active[s.sel]) next_s.size[s.sel] = cfg_wdata[mxd_pkg::OFF_W-1:0];
        default: ;
      endcase
    end
    if (en_we) begin
      next_s.en = en_wdata[NCH-1:0];
    end
    // readback of the selected channel
    unique case (cfg_idx)
      mxd_pkg::CFG_CTRL: next_s.rdata = {4'h0, s.ctrl[s.sel]};
      mxd_pkg::CFG_BASE: next_s.rdata = s.base[s.sel];
      mxd_pkg::CFG_OFF:  next_s.rdata = {2'h0, s.off[s.sel]};
      mxd_pkg::CFG_SIZE: next_s.rdata = {2'h0, s.size[s.sel]};
      mxd_pkg::CFG_MODE: next_s.rdata = {11'h000, s.wrap[s.sel]};
      mxd_pkg::CFG_SEL:  next_s.rdata = {9'h000, s.sel};
      default:           next_s.rdata = '0;
    endcase
    unique case (s.st)
      mxd_pkg::MXD_IDLE: begin
        if (start) begin
          next_s.st   = mxd_pkg::MXD_RUN;
          next_s.gr   = pick;
          next_s.left = s.ctrl[pick][mxd_pkg::CTL_WORD] ? mxd_pkg::BYTES_WORD : mxd_pkg::BYTES_BYTE;
        end
      end
      mxd_pkg::MXD_RUN: begin
        if (!hold) begin
          // second cycle writes the byte read before
          if (s.pipe_v) begin
            sfr_wr        = 1'b1;
            next_s.pipe_v = 1'b0;
          end
          if (step) begin
            // one cycle copy into xram, else read stage
            if (to_x) begin
              sfr_rd  = 1'b1;
              xram_wr = 1'b1;
            end else begin
              xram_rd       = 1'b1;
              next_s.pipe_v = 1'b1;
              next_s.pipe_d = xram_rdata;
            end
            next_s.off[s.gr] = inc_off;
            next_s.left      = s.left - 2'h1;
            if (inc_off == mid_off) begin
              next_s.mid[s.gr] = 1'b1;
            end
            // last byte: flag, then wrap or stop
            if (inc_off == s.size[s.gr]) begin
              next_s.full[s.gr] = 1'b1;
              next_s.left       = 2'h0;
              if (s.wrap[s.gr]) begin
                next_s.off[s.gr] = '0;
              end
            end
          end
          // transaction ends once all bytes are written
          if ((next_s.left == 2'h0) && !next_s.pipe_v) begin
            next_s.st             = mxd_pkg::MXD_IDLE;
            next_s.force_req[s.gr] = 1'b0;
            func_ack[s.ctrl[s.gr][2:0]] = 1'b1;
          end
        end
      end
    endcase
    // software set wins over completion clear
    next_s.force_req = next_s.force_req | act_set;
  end

  // state register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign xram_addr  = s.base[s.gr] + {2'h0, s.off[s.gr]};
  assign xram_wdata = sfr_rdata;
  assign sfr_wdata  = s.pipe_d;
  assign sfr_func   = s.ctrl[s.gr][2:0];
  assign sfr_msb_first = s.ctrl[s.gr][mxd_pkg::CTL_ENDIAN];
  assign cfg_rdata  = s.rdata;

  // status registers, bit 7 reads zero
  assign channel_enable_register   = {1'b0, s.en};
  assign channel_active_register   = {1'b0, active};
  assign full_length_flag_register = {1'b0, s.full};
  assign midpoint_flag_register    = {1'b0, s.mid};

  always_comb begin
    irq = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      irq = irq | (s.full[i] & s.ctrl[i][mxd_pkg::CTL_FULL_IE]) | (s.mid[i] & s.ctrl[i][mxd_pkg::CTL_MID_IE]);
    end
  end

  assign sleep_ok = (s.st == mxd_pkg::MXD_IDLE) && !(|elig) && !(|s.force_req);

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  cpu_wins_a: assert property (cpu_busy |-> !xram_rd && !xram_wr && !sfr_rd && !sfr_wr)
    else $error("engine used bus while cpu busy");
  enable_gate_a: assert property (start |-> s.en[pick])
    else $error("transaction started on disabled channel");
  stall_gate_a: assert property (start |-> !s.ctrl[pick][mxd_pkg::CTL_STALL])
    else $error("transaction started on stalled channel");
  flag_gate_a: assert property (start |-> !s.full[pick] && !s.mid[pick])
    else $error("transaction started with flag pending");
  priority_pick_a: assert property (start |-> ((elig & ((7'h01 << pick) - 7'h01)) == 7'h00))
    else $error("lower priority channel granted");
  read_then_write_a: assert property (xram_rd ##1 !hold |-> sfr_wr && sfr_wdata == $past(xram_rdata))
    else $error("xram byte not written to sfr next cycle");
  offset_count_a: assert property (step && !(inc_off == s.size[s.gr] && s.wrap[s.gr])
    |=> s.off[$past(s.gr)] == $past(inc_off))
    else $error("offset did not advance by one");
  full_set_a: assert property (step && inc_off == s.size[s.gr] |=> s.full[$past(s.gr)])
    else $error("full-length flag not set at end");
  wrap_zero_a: assert property (step && inc_off == s.size[s.gr] && s.wrap[s.gr] |=> s.off[$past(s.gr)] == '0)
    else $error("offset did not wrap to zero");
  addr_lock_a: assert property (cfg_we && cfg_idx == mxd_pkg::CFG_BASE && active[s.sel] && !step
    |=> s.base[$past(s.sel)] == $past(s.base[s.sel]))
    else $error("base changed on active channel");
  top_bit_a: assert property (channel_enable_register[7] == 1'b0)
    else $error("enable register bit 7 not zero");
  enable_load_a: assert property (en_we |=> s.en == $past(en_wdata[NCH-1:0]))
    else $error("enable bits not loaded");

  full_cover_c: cover property (step && inc_off == s.size[s.gr]);
  wrap_cover_c: cover property (step && inc_off == s.size[s.gr] && s.wrap[s.gr]);
  preempt_cover_c: cover property (s.st == mxd_pkg::MXD_RUN && cpu_busy);
  compete_cover_c: cover property (start && $countones(elig) > 1);
endmodule : mxd_engine

// File: verification/mxd_peer.sv
// xram memory and peripheral data source facing the transfer engine
`timescale 1ns/1ps
module mxd_peer (
  // clock
  input  wire logic        clock,
  // xram side
  input  wire logic [11:0] xram_addr,
  input  wire logic        xram_rd,
  input  wire logic        xram_wr,
  input  wire logic [7:0]  xram_wdata,
  output logic      [7:0]  xram_rdata,
  // sfr side
  output logic      [7:0]  sfr_rdata
);
  logic [7:0] mem [0:4095];
  logic [7:0] last;
  // memory preset to an address pattern
  initial begin
    for (int a = 0; a < 4096; a++) mem[a] = 8'(a) ^ 8'ha5;
    last = 8'h00;
    sfr_rdata = 8'h00;
  end
  // peripheral byte changes every cycle, stores land on the edge
  always @(posedge clock) begin
    sfr_rdata <= sfr_rdata + 8'h3b;
    if (xram_wr) mem[xram_addr] <= xram_wdata;
    if (xram_rd) last <= mem[xram_addr];
  end
  // read data only while strobed, otherwise not the last value
  assign xram_rdata = xram_rd ? mem[xram_addr] : ~last;
endmodule : mxd_peer

// File: verification/tb_top.sv
// self-checking bench of the transfer engine
`timescale 1ns/1ps
module tb_top;
  logic        clock, rstn, cfg_we, en_we, cpu_busy, debug_mode, irq, sleep_ok;
  logic        xram_rd, xram_wr, sfr_rd, sfr_wr, sfr_msb_first;
  logic [2:0]  cfg_idx, sfr_func;
  logic [11:0] cfg_wdata, cfg_rdata, xram_addr;
  logic [7:0]  en_wdata, channel_enable_register, channel_active_register, full_length_flag_register;
  logic [7:0]  midpoint_flag_register, func_req, func_ack, xram_wdata, xram_rdata, sfr_wdata, sfr_rdata;
  logic [6:0]  act_set, clr_full, clr_mid, ef, em, blk, fie, wrp;
  logic [7:0]  q[$];
  int          failures, cmp_count, c, lastc, n;
  int          base[7], off[7], size[7], chan_of[8], order[$];

  mxd_engine i_dut (.clock, .rstn, .cfg_we, .cfg_idx, .cfg_wdata, .cfg_rdata, .en_we, .en_wdata,
    .channel_enable_register, .act_set, .channel_active_register, .clr_full, .clr_mid,
    .full_length_flag_register, .midpoint_flag_register, .irq, .func_req, .func_ack, .cpu_busy,
    .debug_mode, .sleep_ok, .xram_addr, .xram_rd, .xram_wr, .xram_wdata, .xram_rdata, .sfr_func,
    .sfr_rd, .sfr_wr, .sfr_wdata, .sfr_rdata, .sfr_msb_first);
  mxd_peer i_peer (.clock, .xram_addr, .xram_rd, .xram_wr, .xram_wdata, .xram_rdata, .sfr_rdata);

  // clock generator
  always #20 clock = ~clock;

  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
    cmp_count++;
    if (e !== s) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  function automatic int mp(input int s);
    return s / 2 + s % 2;
  endfunction : mp

  task automatic cfg(input logic [2:0] i, input logic [11:0] d);
    @(posedge clock);
    cfg_we <= 1'b1;
    cfg_idx <= i;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_we <= 1'b0;
  endtask : cfg

  task automatic setch(input int ch, input logic [7:0] ctl);
    cfg(mxd_pkg::CFG_SEL, 12'(ch));
    cfg(mxd_pkg::CFG_CTRL, {4'h0, ctl});
    cfg(mxd_pkg::CFG_BASE, 12'(base[ch]));
    cfg(mxd_pkg::CFG_SIZE, 12'(size[ch]));
    cfg(mxd_pkg::CFG_OFF, 12'h000);
    off[ch] = 0;
    chan_of[ctl[2:0]] = ch;
    fie[ch] = ctl[7];
    blk[ch] = ctl[5];
    cfg_idx <= mxd_pkg::CFG_SIZE;
    repeat (2) @(posedge clock);
    #1 chk("size readback", 12'(size[ch]), cfg_rdata);
  endtask : setch

  task automatic pulse(input logic [6:0] a, input logic [6:0] cl);
    @(posedge clock);
    act_set <= a;
    clr_full <= cl;
    clr_mid <= cl;
    @(posedge clock);
    act_set <= 7'h00;
    clr_full <= 7'h00;
    clr_mid <= 7'h00;
    ef &= ~cl;
    em &= ~cl;
  endtask : pulse

  // hold requests until the engine goes idle, optionally with random bus holds
  task automatic run(input logic [7:0] req, input bit rnd);
    func_req <= req;
    lastc = 0;
    repeat (3) @(posedge clock);
    n = 0;
    while (n < 1000 && sleep_ok !== 1'b1) begin
      @(posedge clock);
      cpu_busy <= rnd ? 1'($urandom) : 1'b0;
      debug_mode <= rnd ? 1'($urandom) : 1'b0;
      n++;
    end
    cpu_busy <= 1'b0;
    debug_mode <= 1'b0;
    func_req <= 8'h00;
    if (n == 1000) begin
      failures++;
      $display("ERROR run expected idle seen busy");
      end_sim();
    end
    repeat (2) @(posedge clock);
    #1 chk("full flags", {1'b0, ef}, full_length_flag_register);
    chk("mid flags", {1'b0, em}, midpoint_flag_register);
    chk("irq", 12'(|((ef | em) & fie)), 12'(irq));
  endtask : run

  // reference model follows every byte strobe
  always @(posedge clock) begin
    if (rstn && (xram_rd || xram_wr || sfr_rd || sfr_wr) && (cpu_busy || debug_mode))
      chk("strobe under hold", 12'h000, 12'h001);
    if (rstn && (xram_rd || xram_wr)) begin
      c = chan_of[sfr_func];
      chk("blocked channel", 12'h000, 12'(blk[c] | ef[c] | em[c]));
      chk("grant order", 12'h001, 12'(c >= lastc));
      chk("xram addr", 12'(base[c] + off[c]), xram_addr);
      if (xram_rd) q.push_back(xram_addr[7:0] ^ 8'ha5);
      else chk("xram wdata", 12'(sfr_rdata), 12'(xram_wdata));
      order.push_back(c);
      lastc = c;
      off[c]++;
      if (off[c] == mp(size[c])) em[c] = 1'b1;
      if (off[c] == size[c]) begin
        ef[c] = 1'b1;
        if (wrp[c]) off[c] = 0;
      end
    end
    if (rstn && sfr_wr) chk("sfr wdata", 12'(q.pop_front()), 12'(sfr_wdata));
  end

  initial begin
    {clock, rstn, cfg_we, en_we, cpu_busy, debug_mode} = '0;
    {cfg_idx, cfg_wdata, en_wdata, func_req, act_set, clr_full, clr_mid} = '0;
    {ef, em, blk, fie, wrp, failures, cmp_count, lastc} = '0;
    void'($urandom(22216));
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    #1 chk("sleep after reset", 12'h001, 12'(sleep_ok));
    chk("enable reset", 12'h000, 12'(channel_enable_register));
    @(posedge clock);
    en_we <= 1'b1;
    en_wdata <= 8'hff;
    @(posedge clock);
    en_we <= 1'b0;
    @(posedge clock);
    #1 chk("enable bit7", 12'h07f, 12'(channel_enable_register));
    for (int i = 0; i < 3; i++) begin
      base[i] = i * 1024 + $urandom_range(0, 512);
      size[i] = $urandom_range(3, 9);
    end
    setch(0, 8'hc0 | mxd_pkg::FN_X2CRC);
    setch(1, 8'h00 | mxd_pkg::FN_SPI2X);
    setch(2, 8'hc0 | mxd_pkg::FN_X2ENC);
    run(8'h15, 1'b0);
    chk("first grant", 12'h000, 12'(order[0]));
    pulse(7'h00, 7'h07);
    // fresh offsets so the second run moves data; channel 0 wraps at its end
    setch(0, 8'hc0 | mxd_pkg::FN_X2CRC);
    cfg(mxd_pkg::CFG_MODE, 12'h001);
    wrp[0] = 1'b1;
    setch(1, 8'h00 | mxd_pkg::FN_SPI2X);
    setch(2, 8'hc0 | mxd_pkg::FN_X2ENC);
    run(8'h15, 1'b1);
    pulse(7'h00, 7'h07);
    setch(1, 8'h00 | mxd_pkg::FN_SPI2X);
    setch(2, 8'he0 | mxd_pkg::FN_X2ENC);
    @(posedge clock);
    en_we <= 1'b1;
    en_wdata <= 8'h05;
    @(posedge clock);
    en_we <= 1'b0;
    blk[1] = 1'b1;
    run(8'h15, 1'b0);
    #1 chk("active after stall", 12'h000, 12'(channel_active_register));
    setch(2, 8'hc0 | mxd_pkg::FN_X2ENC);
    pulse(7'h04, 7'h00);
    run(8'h00, 1'b0);
    cfg_idx <= mxd_pkg::CFG_OFF;
    repeat (2) @(posedge clock);
    #1 chk("forced offset", 12'h001, cfg_rdata);
    end_sim();
  end
endmodule : tb_top
